// *** hw/mdpp_top.sv ***
// memory address decode, chip selects and boot-memory port sequencer
`timescale 1ns/100ps
module mdpp_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic bus_req,
  input wire logic [31:0] bus_addr,
  input wire logic bus_write,
  input wire logic [2:0] bus_burst_len,
  input wire logic [3:0] bus_byte_en,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic bus_done,
  output logic bus_error,
  output logic [7:0] bus_trap_code,
  output logic correction_error,
  input wire logic cfg_load,
  input wire logic [mdpp_pkg::MDPP_CFG_W-1:0] cfg_word_in,
  input wire logic cfg_io_width8,
  input wire logic cfg_ram_width8,
  input wire logic cfg_ram_correction,
  input wire logic cfg_sdram_enable,
  output logic [mdpp_pkg::MDPP_CFG_W-1:0] boot_io_config_word,
  input wire logic [2:0] gpio_strap,
  input wire logic bus_ready_n,
  output logic [mdpp_pkg::MDPP_ADDR_W-1:0] mem_addr,
  input wire logic [31:0] mem_data_in,
  output logic [31:0] mem_data_out,
  output logic mem_data_oe_n,
  input wire logic [7:0] check_bits_in,
  output logic [7:0] check_bits,
  output logic check_bits_oe_n,
  output logic [1:0] boot_bank_select_n,
  output logic io_select_n,
  output logic [4:0] ram_select_n,
  output logic [1:0] sdram_select_n,
  output logic mem_oe_n,
  output logic mem_read,
  output logic mem_write_n
);
  import mdpp_pkg::*;

  function automatic logic [7:0] mdpp_check(input logic [31:0] d);
    logic [7:0] c;
    c = '0;
    for (int j = 0; j < 32; j++) begin
      c[j % 8] = c[j % 8] ^ d[j];
    end
    return c;
  endfunction

  logic [2:0] strap_s1_q, strap_s2_q;
  logic rdy_s1_q, rdy_s2_q, rdy_s3_q;
  logic [31:0] din_s1_q, din_s2_q;
  logic [7:0] cbin_s1_q, cbin_s2_q;
  mdpp_state_e state_q, state_d;
  logic [31:0] addr_q, wd_q;
  logic [MDPP_SEL_W-1:0] sel_d, sel_n_q;
  logic [4:0] cnt_q;
  logic [2:0] beat_q, beat_d, words_q, last_beat;
  logic [3:0] be_q;
  logic [7:0] chk_q;
  logic [1:0] cap_q;
  logic write_q, narrow_q, corr_q, gate_q, boot_q, err_q;
  logic in_space, is_boot, is_io, is_sdram, narrow_d, corr_d, blocked, start;
  logic ready_low, leave_data, data_phase, drive_phase, byte_ok;
  logic [31:0] word_src;

  // pins are asynchronous to ref_clk, two stages before use
  always_ff @(posedge ref_clk) begin
    strap_s1_q <= gpio_strap;
    strap_s2_q <= strap_s1_q;
    din_s1_q <= mem_data_in;
    din_s2_q <= din_s1_q;
    cbin_s1_q <= check_bits_in;
    cbin_s2_q <= cbin_s1_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdy_s1_q <= 1'b1;
      rdy_s2_q <= 1'b1;
      rdy_s3_q <= 1'b1;
    end else begin
      rdy_s1_q <= bus_ready_n;
      rdy_s2_q <= rdy_s1_q;
      rdy_s3_q <= rdy_s2_q;
    end
  end

  // extra stage in asynchronous mode trades one cycle for more settling
  assign ready_low = boot_io_config_word[MDPP_CFG_RDY_ASYNC] ? !rdy_s3_q : !rdy_s2_q;

  // straps are caught on every reset edge, so they must stand through reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      boot_io_config_word <= '0;
      boot_io_config_word[MDPP_CFG_RWS +: 4] <= MDPP_WAIT_MAX;
      boot_io_config_word[MDPP_CFG_WWS +: 4] <= MDPP_WAIT_MAX;
      boot_io_config_word[MDPP_CFG_WIDTH +: 2] <= strap_s2_q[1:0];
      boot_io_config_word[MDPP_CFG_CORR] <= strap_s2_q[MDPP_STRAP_CORR];
      boot_io_config_word[MDPP_CFG_WEN] <= 1'b0;
    end else if (cfg_load) begin
      boot_io_config_word <= cfg_word_in;
    end
  end

  // address decode
  assign in_space = bus_addr <= MDPP_SPACE_END;
  assign is_boot = bus_addr < MDPP_IO_BASE;
  assign is_io = !is_boot && bus_addr < MDPP_RAM_BASE;
  assign is_sdram = cfg_sdram_enable && bus_addr >= MDPP_RAM_UPPER && in_space;

  always_comb begin
    sel_d = '0;
    if (is_boot) begin
      sel_d[MDPP_SEL_BOOT] = bus_addr < MDPP_BOOT1_BASE;
      sel_d[MDPP_SEL_BOOT + 1] = bus_addr >= MDPP_BOOT1_BASE;
    end else if (is_io) begin
      sel_d[MDPP_SEL_IO] = 1'b1;
    end else if (is_sdram) begin
      sel_d[MDPP_SEL_SDRAM] = bus_addr < MDPP_SDRAM1_BASE;
      sel_d[MDPP_SEL_SDRAM + 1] = bus_addr >= MDPP_SDRAM1_BASE;
    end else if (in_space && bus_addr < MDPP_RAM_UPPER) begin
      sel_d[MDPP_SEL_RAM + int'(bus_addr[MDPP_SRAM_BANK_LSB +: 2])] = 1'b1;
    end else if (in_space && bus_addr < MDPP_SDRAM1_BASE) begin
      sel_d[MDPP_SEL_SRAM4] = 1'b1;
    end
  end

  always_comb begin
    if (is_boot) begin
      narrow_d = boot_io_config_word[MDPP_CFG_WIDTH +: 2] == MDPP_WIDTH_8;
      corr_d = boot_io_config_word[MDPP_CFG_CORR];
    end else if (is_io) begin
      narrow_d = cfg_io_width8;
      corr_d = 1'b0;
    end else begin
      narrow_d = cfg_ram_width8 && !is_sdram;
      corr_d = cfg_ram_correction;
    end
  end

  assign blocked = is_boot && bus_write && !boot_io_config_word[MDPP_CFG_WEN];
  // done is still high in the cycle a requester drops its request
  assign start = state_q == MDPP_IDLE && bus_req && !bus_done;
  assign last_beat = !narrow_q ? 3'h0 : (corr_q ? MDPP_CHECK_BEAT : MDPP_LAST_BYTE);
  assign leave_data = (state_q == MDPP_DATA && cnt_q == 5'h0_0 && !gate_q) ||
                      (state_q == MDPP_STRETCH && ready_low);

  always_comb begin
    state_d = state_q;
    beat_d = beat_q;
    unique case (state_q)
      MDPP_IDLE: if (start) state_d = MDPP_SETUP;
      MDPP_SETUP: state_d = err_q ? MDPP_FINISH : (write_q ? MDPP_LEAD_IN : MDPP_DATA);
      MDPP_LEAD_IN: state_d = MDPP_DATA;
      MDPP_DATA: begin
        if (cnt_q == 5'h0_0) begin
          state_d = gate_q ? MDPP_STRETCH : (write_q ? MDPP_LEAD_OUT : MDPP_DRAIN);
        end
      end
      MDPP_STRETCH: if (ready_low) state_d = write_q ? MDPP_LEAD_OUT : MDPP_DRAIN;
      MDPP_DRAIN: begin
        if (cap_q[1]) begin
          if (beat_q == last_beat) begin
            state_d = MDPP_FINISH;
          end else begin
            state_d = MDPP_DATA;
            beat_d = beat_q + 3'h1;
          end
        end
      end
      MDPP_LEAD_OUT: begin
        if (beat_q == last_beat) begin
          state_d = MDPP_FINISH;
        end else begin
          state_d = MDPP_LEAD_IN;
          beat_d = beat_q + 3'h1;
        end
      end
      MDPP_FINISH: begin
        state_d = (words_q != 3'h0 && !err_q) ? MDPP_SETUP : MDPP_IDLE;
        beat_d = 3'h0;
      end
      default: state_d = MDPP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= MDPP_IDLE;
      beat_q <= 3'h0;
    end else begin
      state_q <= state_d;
      beat_q <= beat_d;
    end
  end

  // access attributes, held across a burst except the address and word count, which step per word
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_q <= '0;
      be_q <= '0;
      words_q <= '0;
      write_q <= 1'b0;
      narrow_q <= 1'b0;
      corr_q <= 1'b0;
      gate_q <= 1'b0;
      boot_q <= 1'b0;
      err_q <= 1'b0;
      bus_trap_code <= '0;
    end else if (start) begin
      addr_q <= bus_addr;
      be_q <= bus_byte_en;
      words_q <= bus_burst_len;
      write_q <= bus_write;
      narrow_q <= narrow_d;
      corr_q <= corr_d;
      gate_q <= is_boot && boot_io_config_word[MDPP_CFG_RDY_EN];
      boot_q <= is_boot;
      err_q <= blocked || !in_space;
      bus_trap_code <= blocked ? MDPP_TRAP_WRITE : (in_space ? 8'h00 : MDPP_TRAP_DECODE);
    end else if (state_q == MDPP_FINISH && words_q != 3'h0) begin
      addr_q <= addr_q + MDPP_WORD_STEP;
      words_q <= words_q - 3'h1;
    end
  end

  // chip selects stand for the whole access or burst
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sel_n_q <= '1;
    end else if (start) begin
      sel_n_q <= (blocked || !in_space) ? '1 : ~sel_d;
    end else if (state_d == MDPP_IDLE) begin
      sel_n_q <= '1;
    end
  end
  assign boot_bank_select_n = sel_n_q[MDPP_SEL_BOOT +: 2];
  assign io_select_n = sel_n_q[MDPP_SEL_IO];
  assign ram_select_n = sel_n_q[MDPP_SEL_RAM +: 5];
  assign sdram_select_n = sel_n_q[MDPP_SEL_SDRAM +: 2];

  // wait counter: twice the programmed value on the boot port only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (state_d == MDPP_DATA && state_q != MDPP_DATA) begin
      if (write_q) begin
        cnt_q <= boot_q ? {boot_io_config_word[MDPP_CFG_WWS +: 4], 1'b0} : 5'h0_0;
      end else begin
        cnt_q <= (boot_q ? {boot_io_config_word[MDPP_CFG_RWS +: 4], 1'b0} : 5'h0_0) + 5'h0_1;
      end
    end else if (state_q == MDPP_DATA && cnt_q != 5'h0_0) begin
      cnt_q <= cnt_q - 5'h0_1;
    end
  end

  // external strobes, registered from the next state
  assign data_phase = state_d == MDPP_DATA || state_d == MDPP_STRETCH;
  assign drive_phase = write_q && (data_phase || state_d == MDPP_LEAD_IN || state_d == MDPP_LEAD_OUT);
  // without correction a narrow store only strobes the bytes it needs
  assign byte_ok = !narrow_q || corr_q || beat_q == MDPP_CHECK_BEAT || be_q[~beat_q[1:0]];
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mem_oe_n <= 1'b1;
      mem_read <= 1'b0;
      mem_write_n <= 1'b1;
      mem_data_oe_n <= 1'b1;
      check_bits_oe_n <= 1'b1;
      mem_addr <= '0;
    end else begin
      mem_oe_n <= !(data_phase && !write_q);
      // a new request is not in write_q yet at its take edge
      mem_read <= (start ? !bus_write && in_space : !write_q && !err_q) &&
                  state_d != MDPP_IDLE && state_d != MDPP_FINISH;
      mem_write_n <= !(data_phase && write_q && byte_ok && !err_q);
      mem_data_oe_n <= !drive_phase;
      check_bits_oe_n <= !(drive_phase && !narrow_q);
      mem_addr <= narrow_q ? {addr_q[MDPP_ADDR_W-1:2], 2'b00} + MDPP_ADDR_W'(beat_d)
                           : addr_q[MDPP_ADDR_W-1:0];
    end
  end

  assign word_src = beat_q == 3'h0 ? bus_wdata : wd_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wd_q <= '0;
      mem_data_out <= '0;
      check_bits <= '0;
    end else if (state_q == MDPP_LEAD_IN) begin
      wd_q <= word_src;
      check_bits <= mdpp_check(word_src);
      if (!narrow_q) begin
        mem_data_out <= word_src;
      end else if (beat_q == MDPP_CHECK_BEAT) begin
        mem_data_out <= {mdpp_check(word_src), 24'h00_0000};
      end else begin
        mem_data_out <= {word_src[{~beat_q[1:0], 3'b000} +: 8], 24'h00_0000};
      end
    end
  end

  // read capture two cycles after the last data cycle, matching the pin stages
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cap_q <= '0;
      bus_rdata <= '0;
      chk_q <= '0;
    end else begin
      cap_q <= {cap_q[0], leave_data && !write_q};
      if (cap_q[1] && !narrow_q) begin
        bus_rdata <= din_s2_q;
        chk_q <= cbin_s2_q;
      end else if (cap_q[1] && beat_q == MDPP_CHECK_BEAT) begin
        chk_q <= din_s2_q[31:24];
      end else if (cap_q[1]) begin
        bus_rdata[{~beat_q[1:0], 3'b000} +: 8] <= din_s2_q[31:24];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_done <= 1'b0;
      bus_error <= 1'b0;
      correction_error <= 1'b0;
    end else begin
      bus_done <= state_q == MDPP_FINISH;
      bus_error <= state_q == MDPP_FINISH && err_q;
      correction_error <= state_q == MDPP_FINISH && !err_q && !write_q && corr_q &&
                          mdpp_check(bus_rdata) != chk_q;
    end
  end

  // helper: length of each enable-low stretch
  logic [5:0] oe_len_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || mem_oe_n) oe_len_q <= '0;
    else oe_len_q <= oe_len_q + 6'h01;
  end

  default clocking mdpp_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_boot0_decode: assert property (
    (state_q == MDPP_SETUP && !err_q && addr_q < MDPP_BOOT1_BASE) |-> boot_bank_select_n == 2'b10)
    else $error("boot select 0 decode wrong");
  chk_boot1_decode: assert property (
    (state_q == MDPP_SETUP && !err_q && boot_q && addr_q >= MDPP_BOOT1_BASE)
      |-> boot_bank_select_n == 2'b01)
    else $error("boot select 1 decode wrong");
  chk_io_decode: assert property (
    (state_q == MDPP_SETUP && !err_q && addr_q >= MDPP_IO_BASE && addr_q < MDPP_RAM_BASE)
      |-> !io_select_n && &boot_bank_select_n && &ram_select_n)
    else $error("io area decode wrong");
  chk_ram_decode: assert property (
    (state_q == MDPP_SETUP && !err_q && addr_q >= MDPP_RAM_BASE &&
      (addr_q < MDPP_SDRAM1_BASE || cfg_sdram_enable))
      |-> io_select_n && (!(&ram_select_n) || !(&sdram_select_n)))
    else $error("ram area decode wrong");
  chk_read_two_cycles: assert property (
    ($fell(mem_oe_n) && boot_q && !gate_q && boot_io_config_word[MDPP_CFG_RWS +: 4] == 4'h0)
      |-> !mem_oe_n ##1 !mem_oe_n ##1 mem_oe_n)
    else $error("zero-wait read not two data cycles");
  chk_wait_double: assert property (
    ($rose(mem_oe_n) && boot_q && !gate_q)
      |-> oe_len_q == {1'b0, boot_io_config_word[MDPP_CFG_RWS +: 4], 1'b0} + 6'h02)
    else $error("read wait count not doubled");
  chk_write_frame: assert property (
    ($fell(mem_write_n) && boot_q && boot_io_config_word[MDPP_CFG_WWS +: 4] == 4'h0 && !gate_q)
      |-> $past(!mem_data_oe_n) ##1 (mem_write_n && !mem_data_oe_n))
    else $error("write lead-in or lead-out missing");
  chk_write_block: assert property (
    (start && blocked) |-> (mem_write_n && boot_bank_select_n == 2'b11) [*3]
      ##1 (bus_error && bus_trap_code == MDPP_TRAP_WRITE))
    else $error("blocked write not trapped");
  chk_check_drive: assert property (
    ($fell(mem_write_n) && !narrow_q) |-> !check_bits_oe_n && check_bits == mdpp_check(wd_q))
    else $error("check bits not driven on write");
  chk_done_quiet: assert property (
    (bus_done && !bus_error) |-> mem_oe_n && mem_write_n && $past(mem_oe_n) && $past(mem_write_n))
    else $error("done before external cycle ended");
  chk_read_strobe: assert property (
    (!mem_oe_n || mem_read) |-> mem_read && !write_q && !err_q)
    else $error("read indicator wrong");
  chk_reset_load: assert property (disable iff (1'b0)
    $rose(rst_n) |-> boot_io_config_word[MDPP_CFG_RWS +: 4] == MDPP_WAIT_MAX &&
      boot_io_config_word[MDPP_CFG_WWS +: 4] == MDPP_WAIT_MAX &&
      boot_io_config_word[MDPP_CFG_WIDTH +: 2] == $past(strap_s2_q[1:0]) &&
      boot_io_config_word[MDPP_CFG_CORR] == $past(strap_s2_q[MDPP_STRAP_CORR]))
    else $error("reset defaults not loaded");

  cov_burst_read: cover property (state_q == MDPP_FINISH && !write_q && words_q != 3'h0);
  cov_narrow_check: cover property (cap_q[1] && narrow_q && beat_q == MDPP_CHECK_BEAT);
  cov_blocked_write: cover property (bus_error && bus_trap_code == MDPP_TRAP_WRITE);
  cov_ready_stretch: cover property (state_q == MDPP_STRETCH ##1 state_q == MDPP_STRETCH);
endmodule // mdpp_top

// *** hw/mdpp_pkg.sv ***
// package: constants and types for the memory decode and boot-memory port
package mdpp_pkg;
  localparam logic [31:0] MDPP_BOOT1_BASE = 32'h1000_0000;
  localparam logic [31:0] MDPP_IO_BASE = 32'h2000_0000;
  localparam logic [31:0] MDPP_RAM_BASE = 32'h4000_0000;
  localparam logic [31:0] MDPP_RAM_UPPER = 32'h6000_0000;
  localparam logic [31:0] MDPP_SDRAM1_BASE = 32'h7000_0000;
  localparam logic [31:0] MDPP_SPACE_END = 32'h7FFF_FFFF;
  localparam logic [31:0] MDPP_WORD_STEP = 32'h0000_0004;
  localparam int MDPP_ADDR_W = 28;
  localparam int MDPP_SRAM_BANK_LSB = 27;
  localparam int MDPP_SEL_W = 10;
  localparam int MDPP_SEL_BOOT = 0;
  localparam int MDPP_SEL_IO = 2;
  localparam int MDPP_SEL_RAM = 3;
  localparam int MDPP_SEL_SRAM4 = 7;
  localparam int MDPP_SEL_SDRAM = 8;
  localparam int MDPP_CFG_W = 14;
  localparam int MDPP_CFG_RWS = 0;
  localparam int MDPP_CFG_WWS = 4;
  localparam int MDPP_CFG_WIDTH = 8;
  localparam int MDPP_CFG_WEN = 10;
  localparam int MDPP_CFG_RDY_EN = 11;
  localparam int MDPP_CFG_RDY_ASYNC = 12;
  localparam int MDPP_CFG_CORR = 13;
  localparam int MDPP_STRAP_CORR = 2;
  localparam logic [3:0] MDPP_WAIT_MAX = 4'hF;
  localparam logic [1:0] MDPP_WIDTH_8 = 2'h1;
  localparam logic [7:0] MDPP_TRAP_WRITE = 8'h2B;
  localparam logic [7:0] MDPP_TRAP_DECODE = 8'h09;
  localparam logic [2:0] MDPP_LAST_BYTE = 3'h3;
  localparam logic [2:0] MDPP_CHECK_BEAT = 3'h4;
  typedef enum logic [7:0] {
    MDPP_IDLE = 8'h01,
    MDPP_SETUP = 8'h02,
    MDPP_LEAD_IN = 8'h04,
    MDPP_DATA = 8'h08,
    MDPP_STRETCH = 8'h10,
    MDPP_DRAIN = 8'h20,
    MDPP_LEAD_OUT = 8'h40,
    MDPP_FINISH = 8'h80
  } mdpp_state_e;
endpackage

// *** verification/mdpp_prom_model.sv ***
// boot memory model: byte array answering behind the boot bank selects
`timescale 1ns/100ps
module mdpp_prom_model (
  input wire logic ref_clk,
  input wire logic [1:0] boot_bank_select_n,
  input wire logic [mdpp_pkg::MDPP_ADDR_W-1:0] mem_addr,
  input wire logic mem_oe_n,
  input wire logic mem_write_n,
  input wire logic [31:0] mem_data_out,
  input wire logic width8,
  input wire logic [3:0] ready_delay,
  output logic [31:0] mem_data_in,
  output logic [7:0] check_bits_in,
  output logic bus_ready_n
);
  import mdpp_pkg::*;
  logic [7:0] mem [0:63];
  logic [5:0] a;
  logic sel;
  logic drv;
  logic act;
  logic [31:0] word;
  logic [31:0] last_d = 32'h0000_0000;
  logic [7:0] last_c = 8'h00;
  logic [3:0] act_cnt = 4'h0;
  assign a = mem_addr[5:0];
  assign sel = (boot_bank_select_n != 2'b11);
  assign drv = sel && !mem_oe_n;
  assign act = sel && (!mem_oe_n || !mem_write_n);
  assign word = width8 ? {mem[a], 24'h00_0000} :
                {mem[a], mem[a + 6'h1], mem[a + 6'h2], mem[a + 6'h3]};
  // released lines show the inverse of the last value, so stale data never matches
  assign mem_data_in = drv ? word : ~last_d;
  assign check_bits_in = drv ? (word[31:24] ^ word[23:16] ^ word[15:8] ^ word[7:0]) : ~last_c;
  // ready pin pulled high; driven low once the access has run ready_delay cycles
  assign bus_ready_n = !(act && (act_cnt >= ready_delay));
  always @(posedge ref_clk) begin
    last_d <= mem_data_in;
    last_c <= check_bits_in;
    act_cnt <= !act ? 4'h0 : ((act_cnt == 4'hF) ? act_cnt : act_cnt + 4'h1);
    if (sel && !mem_write_n && width8) begin
      mem[a] <= mem_data_out[31:24];
    end else if (sel && !mem_write_n) begin
      mem[a] <= mem_data_out[31:24];
      mem[a + 6'h1] <= mem_data_out[23:16];
      mem[a + 6'h2] <= mem_data_out[15:8];
      mem[a + 6'h3] <= mem_data_out[7:0];
    end
  end
endmodule // mdpp_prom_model

// *** verification/tb_mdpp_top.sv ***
// self-checking bench for the memory decode and boot-memory port
`timescale 1ns/100ps
`define CHK(g, e) chk_val((g) === (e), 32'(g), 32'(e))
module tb_mdpp_top;
  import mdpp_pkg::*;
  logic ref_clk, rst_n, bus_req, bus_write, bus_done, bus_error, correction_error, cfg_load;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, mem_data_in, mem_data_out;
  logic [2:0] bus_burst_len, gpio_strap;
  logic [7:0] bus_trap_code, check_bits_in, check_bits, cb_val, trap_got;
  logic [MDPP_CFG_W-1:0] cfg_word_in, boot_io_config_word;
  logic [MDPP_ADDR_W-1:0] mem_addr;
  logic cfg_sdram_enable, bus_ready_n, io_select_n, mem_oe_n, mem_write_n, width8;
  logic err_got, corr_got, cfg_ram_width8;
  logic [1:0] boot_bank_select_n, sdram_select_n;
  logic [4:0] ram_select_n;
  logic [3:0] ready_delay;
  logic [9:0] sel_seen;
  logic [31:0] got [0:7];
  int fail_count = 0;
  int n_tests = 0;
  int oe_cnt, wr_cnt;
  mdpp_top mdpp_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
    .bus_addr(bus_addr), .bus_write(bus_write), .bus_burst_len(bus_burst_len),
    .bus_byte_en(4'hF), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_done(bus_done),
    .bus_error(bus_error), .bus_trap_code(bus_trap_code), .correction_error(correction_error),
    .cfg_load(cfg_load), .cfg_word_in(cfg_word_in), .cfg_io_width8(1'b0),
    .cfg_ram_width8(cfg_ram_width8), .cfg_ram_correction(1'b0),
    .cfg_sdram_enable(cfg_sdram_enable),
    .boot_io_config_word(boot_io_config_word), .gpio_strap(gpio_strap),
    .bus_ready_n(bus_ready_n), .mem_addr(mem_addr), .mem_data_in(mem_data_in),
    .mem_data_out(mem_data_out), .mem_data_oe_n(), .check_bits_in(check_bits_in),
    .check_bits(check_bits), .check_bits_oe_n(), .boot_bank_select_n(boot_bank_select_n),
    .io_select_n(io_select_n), .ram_select_n(ram_select_n), .sdram_select_n(sdram_select_n),
    .mem_oe_n(mem_oe_n), .mem_read(), .mem_write_n(mem_write_n));
  mdpp_prom_model mdpp_prom_model_i (.ref_clk(ref_clk), .boot_bank_select_n(boot_bank_select_n),
    .mem_addr(mem_addr), .mem_oe_n(mem_oe_n), .mem_write_n(mem_write_n),
    .mem_data_out(mem_data_out), .width8(width8), .ready_delay(ready_delay),
    .mem_data_in(mem_data_in), .check_bits_in(check_bits_in), .bus_ready_n(bus_ready_n));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // guarded updates only, so the per-access clears in the tasks never race
  always @(negedge ref_clk) begin
    if (mem_oe_n === 1'b0) oe_cnt <= oe_cnt + 1;
    if (mem_write_n === 1'b0) begin
      wr_cnt <= wr_cnt + 1;
      cb_val <= check_bits;
    end
    if ({sdram_select_n, ram_select_n, io_select_n, boot_bank_select_n} !== 10'h3FF)
      sel_seen <= sel_seen | ~{sdram_select_n, ram_select_n, io_select_n, boot_bank_select_n};
  end
  function automatic void chk_val(input logic ok, input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endfunction
  function automatic logic [13:0] cw(input logic corr, input logic rdy, input logic wen,
                                     input logic w8, input logic [3:0] wws, input logic [3:0] rws);
    return {corr, 1'b0, rdy, wen, w8 ? MDPP_WIDTH_8 : 2'h0, wws, rws};
  endfunction
  task automatic stop_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic set_cfg(input logic [13:0] w);
    @(negedge ref_clk);
    cfg_word_in = w;
    cfg_load = 1'b1;
    @(negedge ref_clk);
    cfg_load = 1'b0;
    `CHK(boot_io_config_word, w);
  endtask
  // request held until its done pulse; a burst keeps it up across words
  task automatic access(input logic [31:0] ad, input logic wr, input logic [2:0] len,
                        input logic [31:0] wd);
    int n;
    @(negedge ref_clk);
    oe_cnt = 0;
    wr_cnt = 0;
    sel_seen = 10'h000;
    bus_addr = ad;
    bus_write = wr;
    bus_burst_len = len;
    bus_wdata = wd;
    bus_req = 1'b1;
    for (int w = 0; w <= len; w++) begin
      n = 0;
      @(negedge ref_clk);
      while (bus_done !== 1'b1 && n < 400) begin
        @(negedge ref_clk);
        n++;
      end
      if (n >= 400) begin
        fail_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        stop_test();
      end
      got[w] = bus_rdata;
    end
    err_got = bus_error;
    corr_got = correction_error;
    trap_got = bus_trap_code;
    bus_req = 1'b0;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 64; i++) mdpp_prom_model_i.mem[i] = 8'(i);
    `CHK(boot_io_config_word, cw(1'b1, 1'b0, 1'b0, 1'b1, 4'hF, 4'hF));
    `CHK({boot_bank_select_n, mem_oe_n, mem_write_n}, 4'hF);
    $display("test reset done");
  endtask
  task automatic t_write;
    width8 = 1'b0;
    access(32'h0000_0008, 1'b1, 3'h0, 32'hA1B2_C3D4);
    `CHK({err_got, trap_got}, {1'b1, MDPP_TRAP_WRITE});
    `CHK(wr_cnt, 0);
    set_cfg(cw(1'b0, 1'b0, 1'b1, 1'b0, 4'h1, 4'h0));
    access(32'h1000_0020, 1'b1, 3'h0, 32'hA1B2_C3D4);
    `CHK(wr_cnt, 3);
    `CHK(cb_val, 8'hA1 ^ 8'hB2 ^ 8'hC3 ^ 8'hD4);
    `CHK(sel_seen, 10'h002);
    access(32'h1000_0020, 1'b0, 3'h0, 32'h0000_0000);
    `CHK(got[0], 32'hA1B2_C3D4);
    // zero write waits: one strobed data cycle between lead-in and lead-out
    set_cfg(cw(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 4'h0));
    access(32'h0000_0010, 1'b1, 3'h0, 32'h0F1E_2D3C);
    `CHK(wr_cnt, 1);
    access(32'h0000_0010, 1'b0, 3'h0, 32'h0000_0000);
    `CHK(got[0], 32'h0F1E_2D3C);
    $display("test write done");
  endtask
  task automatic t_read32;
    logic [3:0] r [0:1];
    r = '{4'h0, 4'h3};
    for (int k = 0; k < 2; k++) begin
      set_cfg(cw(1'b0, 1'b0, 1'b0, 1'b0, 4'hF, r[k]));
      access(32'h0000_0004, 1'b0, 3'h0, 32'h0000_0000);
      `CHK(oe_cnt, 2 + 2 * r[k]);
      `CHK(got[0], 32'h0405_0607);
      `CHK(sel_seen, 10'h001);
    end
    $display("test read32 done");
  endtask
  task automatic t_read8;
    width8 = 1'b1;
    for (int i = 0; i < 4; i++) mdpp_prom_model_i.mem[32 + i] = 8'h5A ^ 8'(i * 8'h33);
    for (int k = 0; k < 3; k++) begin
      set_cfg(cw(k > 0, 1'b0, 1'b0, 1'b1, 4'hF, 4'h0));
      mdpp_prom_model_i.mem[36] = (k == 2) ? 8'h00 : 8'h5A ^ 8'h69 ^ 8'h3C ^ 8'hC3;
      access(32'h0000_0020, 1'b0, 3'h0, 32'h0000_0000);
      `CHK(oe_cnt, (k > 0) ? 10 : 8);
      `CHK(got[0], 32'h5A69_3CC3);
      `CHK(corr_got, k == 2);
    end
    $display("test read8 done");
  endtask
  task automatic t_burst;
    width8 = 1'b0;
    set_cfg(cw(1'b0, 1'b0, 1'b0, 1'b0, 4'hF, 4'h0));
    access(32'h0000_0030, 1'b0, 3'h1, 32'h0000_0000);
    `CHK({got[0], got[1]}, 64'h3031_3233_3435_3637);
    $display("test burst done");
  endtask
  task automatic t_ready;
    ready_delay = 4'h6;
    for (int k = 0; k < 2; k++) begin
      set_cfg(cw(1'b0, 1'b1, 1'b0, 1'b0, 4'hF, 4'h0) | (14'(k) << MDPP_CFG_RDY_ASYNC));
      access(32'h0000_0004, 1'b0, 3'h0, 32'h0000_0000);
      `CHK(oe_cnt > 6, 1'b1);
      `CHK(got[0], 32'h0405_0607);
    end
    ready_delay = 4'h0;
    $display("test ready done");
  endtask
  task automatic t_decode;
    logic [31:0] ad [0:7];
    logic [9:0] ex [0:7];
    ad = '{32'h0000_0040, 32'h1000_0040, 32'h2000_0000, 32'h4000_0000, 32'h4800_0000,
           32'h6000_0000, 32'h7000_0000, 32'h8000_0000};
    ex = '{10'h001, 10'h002, 10'h004, 10'h008, 10'h010, 10'h080, 10'h200, 10'h000};
    // static RAM narrow, synchronous DRAM must stay full width regardless
    cfg_ram_width8 = 1'b1;
    for (int i = 0; i < 8; i++) begin
      cfg_sdram_enable = (i == 6);
      access(ad[i], 1'b0, 3'h0, 32'h0000_0000);
      `CHK(sel_seen, ex[i]);
      `CHK(err_got, i == 7);
      if (i == 7) `CHK(trap_got, MDPP_TRAP_DECODE);
      if (i == 3) `CHK(oe_cnt, 8);
      if (i == 6) `CHK(oe_cnt, 2);
    end
    cfg_ram_width8 = 1'b0;
    $display("test decode done");
  endtask
  initial begin
    rst_n = 1'b0;
    bus_req = 1'b0;
    bus_addr = 32'h0000_0000;
    bus_write = 1'b0;
    bus_burst_len = 3'h0;
    bus_wdata = 32'h0000_0000;
    cfg_load = 1'b0;
    cfg_word_in = 14'h0000;
    cfg_sdram_enable = 1'b0;
    cfg_ram_width8 = 1'b0;
    gpio_strap = 3'h5;
    width8 = 1'b1;
    ready_delay = 4'h0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset();
    t_write();
    t_read32();
    t_read8();
    t_burst();
    t_ready();
    t_decode();
    stop_test();
  end
endmodule // tb_mdpp_top
